//--- pkg/tmc_consts.svh
// Constants for the transceiver mode and wake control block
// Operation
// RL1 - Listen-only: transmitter off, receiver and bias on
// RL2 - Normal mode with mode field 11 gives listen-only
// RL3 - Hold listen-only on low transmit or supply dip
// RL4 - Offline grounds bus, watches wake if enabled
// RL5 - Bus activity biases; silence timeout returns offline
// RL6 - Leaving active: offline if silent, else bias
// RL7 - Active drops on supply dip or undervoltage sleep
// RL8 - Off or overtemp to standby enters offline
// RL9 - Wake pattern or supply dip biases offline bus
// RL10 - Off mode or battery undervoltage switch off
// RL11 - Battery recovery outside off mode re-enters offline
// RL12 - Standard wake watch when selective wake unusable
// RL13 - Wake is dominant, recessive, dominant minimum phases
// RL14 - Phases shorter than minimum are ignored
// RL15 - Pattern outside window resets the detector
// RL16 - Receive high until wake, then flag and low
// RL17 - Wake in sleep raises regulator, requests standby
// RL18 - Mode field bits 1:0 encode four modes
// RL19 - Mode 10 battery undervoltage forces off mode
// RL20 - Bit 4 enables selective wake
// RL21 - Bit 5 marks selective configuration valid
// RL22 - Bit 6 enables flexible data rate tolerance
// RL23 - Device modes sleep 001, standby 100, normal 111
// RL24 - Low transmit input holds listen-only
// RL25 - Reserved control bits read zero, ignore writes
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define TMC_ADDR_W 7
`define TMC_CTRL_ADDR 7'h20
`define TMC_CTRL_RESET 8'h00
`define TMC_CTRL_WMASK 8'h73
`define TMC_BIT_SEL_WAKE 4
`define TMC_BIT_CFG_VALID 5
`define TMC_BIT_FD_TOL 6

// ****************************************
// Mode field codes
// ****************************************
`define TMC_CMC_OFFLINE 2'h0
`define TMC_CMC_ACT_UV 2'h1
`define TMC_CMC_ACT_NOUV 2'h2
`define TMC_CMC_LISTEN 2'h3

// ****************************************
// Timing
// ****************************************
`define TMC_CLK_PERIOD_NS 4
`define TMC_WAKE_DOM_MIN_NS 5000
`define TMC_WAKE_REC_MIN_NS 5000
`define TMC_WAKE_WINDOW_US 1000
`define TMC_SILENCE_TIMEOUT_US 1000
`define TMC_DOM_MIN_CYC \
   ((`TMC_WAKE_DOM_MIN_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_REC_MIN_CYC \
   ((`TMC_WAKE_REC_MIN_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_WINDOW_CYC \
   ((`TMC_WAKE_WINDOW_US * 1000) / `TMC_CLK_PERIOD_NS)
`define TMC_SILENCE_CYC \
   ((`TMC_SILENCE_TIMEOUT_US * 1000 + `TMC_CLK_PERIOD_NS - 1) / \
    `TMC_CLK_PERIOD_NS)

`endif

//--- pkg/tmc_pkg.sv
// Types for the transceiver mode and wake control block
package tmc_pkg;

   // Transceiver operating state
   typedef enum logic [2:0] {
      TMC_ST_OFF     = 3'h0,
      TMC_ST_OFFLINE = 3'h1,
      TMC_ST_OFFBIAS = 3'h2,
      TMC_ST_ACTIVE  = 3'h3,
      TMC_ST_LISTEN  = 3'h4
   } tmc_state_t;

   // Device mode codes
   typedef enum logic [2:0] {
      TMC_DM_SLEEP   = 3'h1,
      TMC_DM_STANDBY = 3'h4,
      TMC_DM_NORMAL  = 3'h7
   } tmc_dev_mode_t;

   // Wake pattern detector phases
   typedef enum logic [1:0] {
      TMC_WK_IDLE = 2'h0,
      TMC_WK_DOM1 = 2'h1,
      TMC_WK_REC  = 2'h2
   } tmc_wake_t;

endpackage

//--- hdl/tmc_span_timer.sv
// Saturating run-length counter, flags when a span reaches its limit
`timescale 1ns/1ps
`default_nettype none
module tmc_span_timer #(
   parameter int unsigned LIMIT = 1
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic run_i,
   output logic hit_o
);

   logic [31:0] cnt_q; // Cycles the span has lasted

   // ****************************************
   // Counter
   // ****************************************
   // Clears as soon as the span breaks, saturates at the limit
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= 32'h0;
      end else if (ce_i) begin
         if (!run_i) begin
            cnt_q <= 32'h0;
         end else if (cnt_q < LIMIT) begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end

   // Span long enough
   assign hit_o = (cnt_q >= LIMIT);

endmodule
`default_nettype wire

//--- hdl/tmc_ctrl_reg.sv
// Transceiver mode control register on the serial control port
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_ctrl_reg
   import tmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [`TMC_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic [7:0] ctrl_o
);

   logic [7:0] ctrl_q; // Stored control bits
   logic hit; // Access aimed at this register

   assign hit = (reg_addr_i == `TMC_CTRL_ADDR);
   assign ctrl_o = ctrl_q;

   // ****************************************
   // Write path
   // ****************************************
   // Only defined bits are stored; reserved bits stay zero
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= `TMC_CTRL_RESET;
      end else if (ce_i && reg_wr_i && hit) begin
         ctrl_q <= reg_wdata_i & `TMC_CTRL_WMASK; // RL25 RL18 RL20 RL21 RL22
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Other addresses belong elsewhere and read zero here
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         reg_rdata_o <= hit ? ctrl_q : 8'h00; // RL25
      end
   end

endmodule
`default_nettype wire

//--- hdl/tmc_mode_wake.sv
// Transceiver mode sequencing and standard bus wake detection
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_mode_wake
   import tmc_pkg::*;
#(
   parameter int unsigned SILENCE_CYC = `TMC_SILENCE_CYC,
   parameter int unsigned WINDOW_CYC = `TMC_WINDOW_CYC
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // Serial control port, decoded register access
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [`TMC_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Device and supply status
   input wire logic [2:0] device_mode_select_i,
   input wire logic dev_off_i,
   input wire logic sleep_by_uv_i,
   input wire logic vcc_uv_i,
   input wire logic bat_uv_i,
   input wire logic bat_recovered_i,
   input wire logic bus_wake_enable_i,
   input wire logic wake_flag_clear_i,
   // Controller and bus side
   input wire logic txd_i,
   input wire logic bus_dom_i,
   output logic rxd_o,
   output logic tx_enable_o,
   output logic rx_enable_o,
   output logic bias_mid_o,
   output logic bias_gnd_o,
   output logic xcvr_off_o,
   output logic [2:0] xcvr_state_o,
   output logic bus_silent_o,
   output logic fd_tolerance_o,
   output logic bus_wake_event_flag_o,
   output logic regulator_switch_out_o,
   output logic standby_req_o,
   output logic off_mode_req_o
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0] ctrl; // Control register contents
   logic [1:0] transceiver_mode_select; // Mode field
   logic selective_wake_enable; // Selective wake on
   logic selective_config_valid; // Selective setup valid
   logic normal; // Device in normal mode
   logic bus_dom_q; // Bus level one cycle ago
   logic bus_edge; // Bus changed level
   logic silent; // No edge for the timeout
   logic dom_long; // Dominant run reached minimum
   logic rec_long; // Recessive run reached minimum
   logic wake_arm; // Standard wake watch allowed
   logic wake_hit; // Complete pattern seen this cycle
   logic want_active; // Mode field asks for active
   tmc_state_t state_q; // Transceiver state
   tmc_state_t state_d; // Its next value
   tmc_wake_t wk_q; // Detector phase
   tmc_wake_t wk_d; // Its next value
   logic [31:0] win_q; // Cycles since pattern start
   logic flag_q; // Wake event flag
   logic reg_sw_q; // Regulator switch state

   // ****************************************
   // Control register
   // ****************************************
   tmc_ctrl_reg u_ctrl (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o),
      .ctrl_o(ctrl)
   );

   // Field split of the control register
   assign transceiver_mode_select = ctrl[1:0]; // RL18
   assign selective_wake_enable = ctrl[`TMC_BIT_SEL_WAKE]; // RL20
   assign selective_config_valid = ctrl[`TMC_BIT_CFG_VALID]; // RL21

   // Mode field only counts while the device is in normal mode
   assign normal = (device_mode_select_i == TMC_DM_NORMAL); // RL23

   // ****************************************
   // Bus activity
   // ****************************************
   // Previous bus level for edge detection
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_dom_q <= 1'b0;
      end else if (ce_i) begin
         bus_dom_q <= bus_dom_i;
      end
   end

   assign bus_edge = bus_dom_i ^ bus_dom_q;

   // Silence: no edge for at least the timeout
   tmc_span_timer #(
      .LIMIT(SILENCE_CYC)
   ) u_silence (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .run_i(!bus_edge),
      .hit_o(silent)
   );

   // Dominant run length; any recessive cycle restarts it
   tmc_span_timer #(
      .LIMIT(`TMC_DOM_MIN_CYC)
   ) u_dom_run (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .run_i(bus_dom_i),
      .hit_o(dom_long)
   );

   // Recessive run length; any dominant cycle restarts it
   tmc_span_timer #(
      .LIMIT(`TMC_REC_MIN_CYC)
   ) u_rec_run (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .run_i(!bus_dom_i),
      .hit_o(rec_long)
   );

   // ****************************************
   // Wake pattern detector
   // ****************************************
   // The watch also runs in offline-bias, because the first edge
   // of a pattern already moves the bus bias up
   assign wake_arm = bus_wake_enable_i &&
                     (!selective_wake_enable || !selective_config_valid) &&
                     ((state_q == TMC_ST_OFFLINE) ||
                      (state_q == TMC_ST_OFFBIAS)); // RL12 RL4

   // Phase sequencing
   always_comb begin
      wk_d = wk_q;
      wake_hit = 1'b0;
      if (!wake_arm) begin
         wk_d = TMC_WK_IDLE;
      end else if ((wk_q != TMC_WK_IDLE) && (win_q >= WINDOW_CYC)) begin
         wk_d = TMC_WK_IDLE; // RL15
      end else begin
         case (wk_q)
            TMC_WK_IDLE: begin
               // Short dominant spikes never reach the minimum
               if (dom_long) begin
                  wk_d = TMC_WK_DOM1; // RL13 RL14
               end
            end
            TMC_WK_DOM1: begin
               if (rec_long) begin
                  wk_d = TMC_WK_REC; // RL13 RL14
               end
            end
            TMC_WK_REC: begin
               if (dom_long) begin
                  wk_d = TMC_WK_IDLE;
                  wake_hit = 1'b1; // RL13
               end
            end
            default: begin
               wk_d = TMC_WK_IDLE;
            end
         endcase
      end
   end

   // Phase register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wk_q <= TMC_WK_IDLE;
      end else if (ce_i) begin
         wk_q <= wk_d;
      end
   end

   // Window timer; starts at the first dominant phase's minimum length,
   // since that much of the phase has already passed when it is recognised
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         win_q <= 32'h0;
      end else if (ce_i) begin
         if (wk_d == TMC_WK_IDLE) begin
            win_q <= 32'h0;
         end else if (wk_q == TMC_WK_IDLE) begin
            win_q <= 32'(`TMC_DOM_MIN_CYC); // RL15
         end else if (win_q < WINDOW_CYC) begin
            win_q <= win_q + 32'h1;
         end
      end
   end

   // ****************************************
   // Wake event flag and regulator switch
   // ****************************************
   // A new wake beats a clear in the same cycle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flag_q <= 1'b0;
      end else if (ce_i) begin
         if (wake_hit) begin
            flag_q <= 1'b1; // RL16
         end else if (wake_flag_clear_i) begin
            flag_q <= 1'b0;
         end
      end
   end

   // Regulator turned on by a wake out of sleep, held until cleared
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_sw_q <= 1'b0;
      end else if (ce_i) begin
         if (wake_hit && (device_mode_select_i == TMC_DM_SLEEP)) begin
            reg_sw_q <= 1'b1; // RL17
         end else if (wake_flag_clear_i) begin
            reg_sw_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // Transceiver state machine
   // ****************************************
   // Active asked for: mode 01 with good supply, or mode 10
   assign want_active = normal &&
      (((transceiver_mode_select == `TMC_CMC_ACT_UV) && !vcc_uv_i) ||
       (transceiver_mode_select == `TMC_CMC_ACT_NOUV)); // RL18

   // Next state; off conditions override everything
   always_comb begin
      state_d = state_q;
      if (dev_off_i || bat_uv_i) begin
         state_d = TMC_ST_OFF; // RL10
      end else begin
         case (state_q)
            TMC_ST_OFF: begin
               // Covers the off/overtemp to standby step as well
               if (bat_recovered_i) begin
                  state_d = TMC_ST_OFFLINE; // RL11 RL8
               end
            end
            TMC_ST_OFFLINE: begin
               if (normal && (transceiver_mode_select ==
                   `TMC_CMC_LISTEN)) begin
                  state_d = TMC_ST_LISTEN; // RL2
               end else if (want_active) begin
                  // Stuck-low transmit must never drive the bus
                  state_d = txd_i ? TMC_ST_ACTIVE : TMC_ST_LISTEN; // RL24
               end else if (wake_hit || bus_edge) begin
                  state_d = TMC_ST_OFFBIAS; // RL5 RL9
               end else if (normal && vcc_uv_i &&
                  (transceiver_mode_select == `TMC_CMC_ACT_UV)) begin
                  state_d = TMC_ST_OFFBIAS; // RL9
               end
            end
            TMC_ST_OFFBIAS: begin
               if (normal && (transceiver_mode_select ==
                   `TMC_CMC_LISTEN)) begin
                  state_d = TMC_ST_LISTEN; // RL2
               end else if (want_active) begin
                  state_d = txd_i ? TMC_ST_ACTIVE : TMC_ST_LISTEN; // RL24
               end else if (silent && !bus_edge && !(normal && vcc_uv_i &&
                  (transceiver_mode_select == `TMC_CMC_ACT_UV))) begin
                  state_d = TMC_ST_OFFLINE; // RL5
               end
            end
            TMC_ST_ACTIVE: begin
               if (normal && (transceiver_mode_select ==
                   `TMC_CMC_LISTEN)) begin
                  state_d = TMC_ST_LISTEN; // RL2
               end else if (want_active) begin
                  state_d = txd_i ? TMC_ST_ACTIVE : TMC_ST_LISTEN; // RL24
               end else begin
                  // Supply dip, sleep by undervoltage, standby, mode 00
                  state_d = silent ? TMC_ST_OFFLINE
                                   : TMC_ST_OFFBIAS; // RL6 RL7
               end
            end
            TMC_ST_LISTEN: begin
               if (normal && (transceiver_mode_select ==
                   `TMC_CMC_LISTEN)) begin
                  state_d = TMC_ST_LISTEN; // RL2
               end else if (normal && (!txd_i || (vcc_uv_i &&
                  (transceiver_mode_select == `TMC_CMC_ACT_UV)))) begin
                  state_d = TMC_ST_LISTEN; // RL3
               end else if (want_active) begin
                  state_d = TMC_ST_ACTIVE;
               end else begin
                  state_d = silent ? TMC_ST_OFFLINE
                                   : TMC_ST_OFFBIAS; // RL6
               end
            end
            default: begin
               state_d = TMC_ST_OFF;
            end
         endcase
      end
   end

   // State register; power-up starts switched off
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= TMC_ST_OFF;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   // Bus drive and bias follow the state one cycle later; the lag
   // keeps every pin glitch free at the cost of 4 ns
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_enable_o <= 1'b0;
         rx_enable_o <= 1'b0;
         bias_mid_o <= 1'b0;
         bias_gnd_o <= 1'b0;
         xcvr_off_o <= 1'b1;
         xcvr_state_o <= 3'h0;
      end else if (ce_i) begin
         // Only active may drive; listen-only stays hands off
         tx_enable_o <= (state_q == TMC_ST_ACTIVE); // RL1
         rx_enable_o <= (state_q != TMC_ST_OFF); // RL1
         bias_mid_o <= (state_q == TMC_ST_ACTIVE) ||
                       (state_q == TMC_ST_LISTEN) ||
                       (state_q == TMC_ST_OFFBIAS); // RL1 RL5
         bias_gnd_o <= (state_q == TMC_ST_OFFLINE); // RL4
         xcvr_off_o <= (state_q == TMC_ST_OFF); // RL10
         xcvr_state_o <= state_q;
      end
   end

   // Receive pin: bus stream when communicating, else wake status
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rxd_o <= 1'b1;
      end else if (ce_i) begin
         if ((state_q == TMC_ST_ACTIVE) || (state_q == TMC_ST_LISTEN)) begin
            rxd_o <= !bus_dom_q;
         end else begin
            rxd_o <= !(flag_q || wake_hit); // RL16
         end
      end
   end

   // Status, event and request outputs
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_silent_o <= 1'b0;
         fd_tolerance_o <= 1'b0;
         bus_wake_event_flag_o <= 1'b0;
         regulator_switch_out_o <= 1'b0;
         standby_req_o <= 1'b0;
         off_mode_req_o <= 1'b0;
      end else if (ce_i) begin
         bus_silent_o <= silent;
         fd_tolerance_o <= ctrl[`TMC_BIT_FD_TOL]; // RL22
         bus_wake_event_flag_o <= flag_q || wake_hit; // RL16
         regulator_switch_out_o <= reg_sw_q || (wake_hit &&
            (device_mode_select_i == TMC_DM_SLEEP)); // RL17
         standby_req_o <= wake_hit &&
            (device_mode_select_i == TMC_DM_SLEEP); // RL17
         off_mode_req_o <= normal && bat_uv_i &&
            (transceiver_mode_select == `TMC_CMC_ACT_NOUV); // RL19
      end
   end

endmodule
`default_nettype wire

//--- sim/tmc_mode_wake_asserts.sv
// Concurrent checks on the transceiver mode and wake block ports
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_mode_wake_asserts
   import tmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic reg_wr_i,
   input wire logic [`TMC_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [2:0] device_mode_select_i,
   input wire logic dev_off_i,
   input wire logic bat_uv_i,
   input wire logic bat_recovered_i,
   input wire logic bus_wake_enable_i,
   input wire logic txd_i,
   input wire logic bus_dom_i,
   input wire logic tx_enable_o,
   input wire logic rx_enable_o,
   input wire logic bias_mid_o,
   input wire logic bias_gnd_o,
   input wire logic xcvr_off_o,
   input wire logic [2:0] xcvr_state_o,
   input wire logic bus_wake_event_flag_o,
   input wire logic regulator_switch_out_o,
   input wire logic standby_req_o,
   input wire logic off_mode_req_o
);
   // ****************************************
   // Shadow of the control register
   // ****************************************
   logic [1:0] mode_q; // Mode field as last written
   logic sel_ok_q; // Selective wake usable, blocks standard wake
   logic norm_c; // Normal mode, not off, battery good (vcc_uv not checked)
   logic offreq_c; // Off mode request cause
   // Mirrors writes so the mode field is visible without a read
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= 2'h0;
         sel_ok_q <= 1'b0;
      end else if (ce_i && reg_wr_i && reg_addr_i == `TMC_CTRL_ADDR) begin
         mode_q <= reg_wdata_i[1:0];
         sel_ok_q <= reg_wdata_i[4] && reg_wdata_i[5];
      end
   end
   assign norm_c = device_mode_select_i == TMC_DM_NORMAL && !dev_off_i
      && !bat_uv_i && bat_recovered_i;
   assign offreq_c = device_mode_select_i == TMC_DM_NORMAL
      && mode_q == 2'h2 && bat_uv_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Three cycles: an OFF start needs one hop through offline
   sequence held_s(logic [1:0] m);
      (ce_i && norm_c && txd_i && mode_q == m)[*3];
   endsequence
   listen_outputs_a:
      assert property (xcvr_state_o == TMC_ST_LISTEN |->
         !tx_enable_o && rx_enable_o && bias_mid_o) else $error("listen drive");
   force_off_a:
      assert property (ce_i && (dev_off_i || bat_uv_i) |-> ##2 xcvr_off_o
         && xcvr_state_o == TMC_ST_OFF) else $error("not forced off");
   offline_gnd_a:
      assert property (bias_gnd_o == (xcvr_state_o == TMC_ST_OFFLINE))
      else $error("ground bias wrong");
   listen_mode_a:
      assert property (held_s(2'h3) |=> xcvr_state_o == TMC_ST_LISTEN)
      else $error("mode 11 not listen");
   active_mode_a:
      assert property (held_s(2'h2) |=> xcvr_state_o == TMC_ST_ACTIVE)
      else $error("mode 10 not active");
   offbias_entry_a:
      assert property (ce_i && device_mode_select_i == TMC_DM_STANDBY
         && !dev_off_i && !bat_uv_i && xcvr_state_o == TMC_ST_OFFLINE
         && $changed(bus_dom_i) |-> ##[1:4] xcvr_state_o == TMC_ST_OFFBIAS)
      else $error("no bias on activity");
   wake_armed_a:
      assert property ($rose(bus_wake_event_flag_o) |->
         $past(bus_wake_enable_i) && !$past(sel_ok_q)) else $error("wake unarmed");
   standby_pulse_a:
      assert property ($rose(standby_req_o) |-> regulator_switch_out_o
         && bus_wake_event_flag_o ##1 !standby_req_o) else $error("standby req");
   off_req_a:
      assert property (ce_i |=> off_mode_req_o == $past(offreq_c))
      else $error("off request wrong");
endmodule
bind tmc_mode_wake tmc_mode_wake_asserts u_chk (.*);
`default_nettype wire

//--- sim/tmc_bus_node.sv
// Bus node model driving the dominant level seen by the transceiver
`timescale 1ns/1ps
`default_nettype none
module tmc_bus_node (
   input wire logic clk_i,
   output logic bus_dom_o
);
   // Released bus rests recessive through the termination
   initial bus_dom_o = 1'b0;
   // Hold one level for n cycles, changed just after an edge
   task automatic phase(input logic lvl, input int n);
      @(posedge clk_i) bus_dom_o <= lvl;
      repeat (n - 1) @(posedge clk_i);
   endtask
   // Dominant, recessive, dominant, then release
   task automatic wake(input int d1, input int r, input int d2);
      phase(1'b1, d1);
      phase(1'b0, r);
      phase(1'b1, d2);
      phase(1'b0, 1);
   endtask
endmodule
`default_nettype wire

//--- sim/test_can_transceiver_mode_wake_control.sv
// Self-checking bench for the transceiver mode and wake block
`timescale 1ns/1ps
`default_nettype none
module test_can_transceiver_mode_wake_control
   import tmc_pkg::*;
;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, rdata;
   logic [2:0] dev_mode = 3'h4, state;
   logic dev_off = 1'b0, vcc_uv = 1'b0, bat_uv = 1'b0, txd = 1'b1;
   logic wake_en = 1'b0, flag_clr = 1'b0, bus_dom, rxd, flag, reg_sw;
   logic off_req, fd_tol, bat_ok = 1'b1;
   int miscompares = 0, num_checks = 0;
   // Wake table: config byte, recessive length, expected hit
   logic [7:0] cfg [5] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h10};
   int rec [5] = '{1260, 600, 5000, 1260, 1260};
   logic hit [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   // Short silence and window keep the run brief
   tmc_mode_wake #(.SILENCE_CYC(50), .WINDOW_CYC(6000)) DUT (
      .clk_i(clk), .reset_n_i(reset_n), .ce_i(1'b1), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(rdata), .device_mode_select_i(dev_mode),
      .dev_off_i(dev_off), .sleep_by_uv_i(1'b0), .bat_uv_i(bat_uv),
      .vcc_uv_i(vcc_uv), .bat_recovered_i(bat_ok), .bus_wake_enable_i(wake_en),
      .wake_flag_clear_i(flag_clr), .txd_i(txd), .bus_dom_i(bus_dom),
      .rxd_o(rxd), .tx_enable_o(), .rx_enable_o(), .bias_mid_o(),
      .bias_gnd_o(), .xcvr_off_o(), .xcvr_state_o(state), .bus_silent_o(),
      .fd_tolerance_o(fd_tol), .bus_wake_event_flag_o(flag),
      .regulator_switch_out_o(reg_sw), .standby_req_o(), .off_mode_req_o(off_req)
   );
   tmc_bus_node node (.clk_i(clk), .bus_dom_o(bus_dom));
   always #2 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a[6:0];
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data settles on the same edge that takes the strobe, one edge after it is driven
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a[6:0];
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge clk);
   endtask
   // Bounded wait, since a mode change may pass through offline bias
   task automatic wait_st(input logic [2:0] e);
      int n = 0;
      while (state !== e && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(8'(state), 8'(e));
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      wait_st(TMC_ST_OFFLINE);
      wr(8'h20, 8'hFF);
      rd_chk(8'h20, 8'h73);
      chk(8'(fd_tol), 8'h01);
      rd_chk(8'h21, 8'h00);
      wake_en <= 1'b1;
      // Idle past the window so each pattern starts fresh
      for (int i = 0; i < 5; i++) begin
         wr(8'h20, cfg[i]);
         node.wake(1260, rec[i], 1260);
         chk(8'(flag), 8'(hit[i]));
         if (hit[i]) chk(8'(rxd), 8'h00);
         flag_clr <= 1'b1;
         node.phase(1'b0, 6100);
         flag_clr <= 1'b0;
      end
      dev_mode <= TMC_DM_SLEEP;
      node.wake(1260, 1260, 1260);
      chk(8'(reg_sw), 8'h01);
      dev_mode <= TMC_DM_NORMAL;
      for (int i = 0; i < 4; i++) begin
         wr(8'h20, 8'(((i + 1) % 4)));
         wait_st(i == 2 ? TMC_ST_LISTEN : i == 3 ? TMC_ST_OFFLINE
            : TMC_ST_ACTIVE);
      end
      txd <= 1'b0;
      wr(8'h20, 8'h01);
      wait_st(TMC_ST_LISTEN);
      txd <= 1'b1;
      wait_st(TMC_ST_ACTIVE);
      vcc_uv <= 1'b1;
      wait_st(TMC_ST_OFFBIAS);
      vcc_uv <= 1'b0;
      wr(8'h20, 8'h02);
      {bat_uv, bat_ok} <= 2'b10;
      repeat (3) @(posedge clk);
      chk(8'(off_req), 8'h01);
      wait_st(TMC_ST_OFF);
      bat_uv <= 1'b0;
      repeat (4) @(posedge clk);
      wait_st(TMC_ST_OFF);
      bat_ok <= 1'b1;
      wait_st(TMC_ST_ACTIVE);
      dev_mode <= TMC_DM_STANDBY;
      wait_st(TMC_ST_OFFLINE);
      node.phase(1'b1, 4);
      node.phase(1'b0, 1);
      wait_st(TMC_ST_OFFBIAS);
      wait_st(TMC_ST_OFFLINE);
      dev_off <= 1'b1;
      wait_st(TMC_ST_OFF);
      dev_off <= 1'b0;
      wait_st(TMC_ST_OFFLINE);
      end_of_test();
   end
endmodule
`default_nettype wire
